/* File: ssrp_pkg.sv */
// Shared constants, types and helpers for the sensor serial register port.
package ssrp_pkg;

    // Clock rate and timing.
    localparam int CLK_PERIOD_NS   = 100;
    localparam int DRDY_PULSE_NS   = 500;
    localparam logic [3:0] DRDY_PULSE_CYC =
        4'((DRDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SAMPLE_BASE_CYC = 20;

    // Frame layout.
    localparam int FRAME_WR_BIT = 15;
    localparam int RATE_BITS    = 14;

    // Byte addresses of the lower bytes.
    localparam logic [6:0] ADDR_RATE   = 7'h04;
    localparam logic [6:0] ADDR_OFFSET = 7'h14;
    localparam logic [6:0] ADDR_GPIO   = 7'h32;
    localparam logic [6:0] ADDR_MISC   = 7'h34;
    localparam logic [6:0] ADDR_SMPL   = 7'h36;
    localparam logic [6:0] ADDR_GCMD   = 7'h3e;

    // Register indices, one per 16-bit word.
    localparam logic [5:0] IDX_RATE   = ADDR_RATE[6:1];
    localparam logic [5:0] IDX_OFFSET = ADDR_OFFSET[6:1];
    localparam logic [5:0] IDX_GPIO   = ADDR_GPIO[6:1];
    localparam logic [5:0] IDX_MISC   = ADDR_MISC[6:1];
    localparam logic [5:0] IDX_SMPL   = ADDR_SMPL[6:1];
    localparam logic [5:0] IDX_GCMD   = ADDR_GCMD[6:1];

    // Field positions.
    localparam int CMD_AUTONULL_BIT = 0;
    localparam int CMD_SAVE_BIT     = 3;
    localparam int MISC_DR_LINE_BIT = 0;
    localparam int MISC_DR_POL_BIT  = 1;
    localparam int MISC_DR_EN_BIT   = 2;
    localparam int OUT_ND_BIT       = 15;
    localparam int OUT_EA_BIT       = 14;

    // Reset values and alarm limit.
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] MISC_RST   = 16'h0000;
    localparam logic [15:0] SMPL_RST   = 16'h0001;
    localparam logic [13:0] RATE_ALARM_LIM = 14'h1110;

    // Control registers that have a flash copy.
    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] misc;
        logic [15:0] smpl;
    } ssrp_cfg_t;

    localparam ssrp_cfg_t CFG_DEFAULT = '{offset: OFFSET_RST, misc: MISC_RST, smpl: SMPL_RST};

    // Serial pins entering the port.
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } ssrp_spi_t;

    typedef enum logic {SSRP_LOAD, SSRP_RUN} ssrp_phase_t;

    // Replace one byte of a register; address bit 0 picks the upper byte.
    function automatic logic [15:0] ssrp_put_byte(input logic [15:0] old,
                                                  input logic       upper,
                                                  input logic [7:0] data);
        ssrp_put_byte = upper ? {data, old[7:0]} : {old[15:8], data};
    endfunction : ssrp_put_byte

    // True for byte addresses that hold writable control state.
    function automatic logic ssrp_writable(input logic [6:0] addr);
        ssrp_writable = (addr[6:1] == IDX_OFFSET) || (addr[6:1] == IDX_MISC) ||
                        (addr[6:1] == IDX_SMPL) || (addr == ADDR_GCMD);
    endfunction : ssrp_writable

endpackage : ssrp_pkg

/* File: ssrp_flash.sv */
// Nonvolatile copy of the backed-up control registers.
`timescale 1ns/100ps
module ssrp_flash (
    // Clock.
    input  wire logic            core_clk_in,
    // Save request and data.
    input  wire logic            save_in,
    input  wire ssrp_pkg::ssrp_cfg_t data_in,
    // Stored contents.
    output ssrp_pkg::ssrp_cfg_t  stored_out
);
    import ssrp_pkg::*;

    // Contents survive the synchronous reset on purpose, as flash would.
    ssrp_cfg_t mem_ff = CFG_DEFAULT;
    ssrp_cfg_t nxt_mem;

    // Only an explicit save changes the stored copy.
    always_comb
    begin
        nxt_mem = save_in ? data_in : mem_ff;
    end

    // Storage register, deliberately without reset.
    always_ff @(posedge core_clk_in)
    begin
        mem_ff <= nxt_mem;
    end

    assign stored_out = mem_ff;

endmodule : ssrp_flash

/* File: ssrp_port.sv */
// Serial slave port, working registers and sample path of the rate sensor.
`timescale 1ns/100ps
module ssrp_port #(
    parameter int unsigned SAMPLE_BASE = ssrp_pkg::SAMPLE_BASE_CYC
) (
    // Clock and reset.
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    // Serial link pins.
    input  wire ssrp_pkg::ssrp_spi_t spi_in,
    output logic                   dout_out,
    output logic                   dout_oe_n_out,
    // Configurable digital lines.
    input  wire logic [1:0]        dio_in,
    output logic      [1:0]        dio_out,
    output logic      [1:0]        dio_oe_n_out,
    // Converter data and calibration trigger.
    input  wire logic [13:0]       rate_sample_in,
    output logic                   autonull_out
);
    import ssrp_pkg::*;

    // All state of the port in one record.
    typedef struct packed {
        ssrp_phase_t phase;
        logic [2:0]  sclk_sy;
        logic [2:0]  cs_n_sy;
        logic [1:0]  din_sy;
        logic [1:0]  dio_sy0;
        logic [1:0]  dio_sy1;
        logic [3:0]  bit_cnt;
        logic [15:0] rx_sh;
        logic [15:0] tx_sh;
        logic [15:0] rd_data;
        logic        dout;
        logic        dout_oe_n;
        ssrp_cfg_t   cfg;
        logic [15:0] rate_out;
        logic [13:0] prev_sample;
        logic [19:0] tick_cnt;
        logic [3:0]  drdy_cnt;
        logic [1:0]  dio;
        logic [1:0]  dio_oe_n;
        logic        save;
        logic        autonull;
    } ssrp_port_state_t;

    localparam ssrp_port_state_t ST_RST = '{phase: SSRP_LOAD, sclk_sy: 3'h7, cs_n_sy: 3'h7,
                                            dout_oe_n: 1'b1, dio_oe_n: 2'h3,
                                            cfg: CFG_DEFAULT, default: '0};

    ssrp_port_state_t st_ff;
    ssrp_port_state_t nxt_st;
    ssrp_cfg_t        flash_cfg;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        sel;
    logic        frame_done;
    logic [15:0] frame_word;
    logic [6:0]  fw_addr;
    logic [7:0]  fw_data;
    logic        fw_wr;
    logic        running;

    // Edges come from the second and third stages; stage one feeds stage two only.
    assign sclk_rise  = st_ff.sclk_sy[1] & ~st_ff.sclk_sy[2];
    assign sclk_fall  = ~st_ff.sclk_sy[1] & st_ff.sclk_sy[2];
    assign cs_fall    = ~st_ff.cs_n_sy[1] & st_ff.cs_n_sy[2];
    assign cs_rise    = st_ff.cs_n_sy[1] & ~st_ff.cs_n_sy[2];
    assign sel        = ~st_ff.cs_n_sy[1];
    assign frame_done = sel & sclk_rise & (st_ff.bit_cnt == 4'hf);
    assign frame_word = {st_ff.rx_sh[14:0], st_ff.din_sy[1]};
    assign fw_wr      = frame_word[FRAME_WR_BIT];
    assign fw_addr    = frame_word[14:8];
    assign fw_data    = frame_word[7:0];
    assign running    = (st_ff.phase == SSRP_RUN);

    // Flash holds the backed-up settings across resets.
    ssrp_flash u_flash (
        .core_clk_in (core_clk_in),
        .save_in     (st_ff.save),
        .data_in     (st_ff.cfg),
        .stored_out  (flash_cfg)
    );

    // Next-state logic for the serial engine, registers and sampler.
    always_comb
    begin
        logic [14:0] sum;
        logic [13:0] filt;
        logic [13:0] corr;
        logic        alarm;
        sum   = '0;
        filt  = '0;
        corr  = '0;
        alarm = 1'b0;
        nxt_st = st_ff;
        nxt_st.save     = 1'b0;
        nxt_st.autonull = 1'b0;
        nxt_st.sclk_sy  = {st_ff.sclk_sy[1:0], spi_in.sclk};
        nxt_st.cs_n_sy  = {st_ff.cs_n_sy[1:0], spi_in.cs_n};
        nxt_st.din_sy   = {st_ff.din_sy[0], spi_in.din};
        nxt_st.dio_sy0  = dio_in;
        nxt_st.dio_sy1  = st_ff.dio_sy0;

        // Shift engine; the first falling edge after select keeps the MSB.
        if (cs_fall)
        begin
            nxt_st.bit_cnt   = 4'h0;
            nxt_st.tx_sh     = st_ff.rd_data;
            nxt_st.dout      = st_ff.rd_data[15];
            nxt_st.dout_oe_n = 1'b0;
        end
        else if (cs_rise)
        begin
            nxt_st.bit_cnt   = 4'h0;
            nxt_st.dout_oe_n = 1'b1;
        end
        else if (sel)
        begin
            if (sclk_rise)
            begin
                nxt_st.rx_sh   = frame_word;
                nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
            end
            if (sclk_fall && st_ff.bit_cnt != 4'h0)
            begin
                nxt_st.tx_sh = {st_ff.tx_sh[14:0], 1'b0};
                nxt_st.dout  = st_ff.tx_sh[14];
            end
        end

        // Completed frame: byte write or read request.
        if (frame_done && running)
        begin
            if (fw_wr)
            begin
                case (fw_addr[6:1])
                    IDX_OFFSET: nxt_st.cfg.offset = ssrp_put_byte(st_ff.cfg.offset, fw_addr[0], fw_data);
                    IDX_MISC:   nxt_st.cfg.misc   = ssrp_put_byte(st_ff.cfg.misc, fw_addr[0], fw_data);
                    IDX_SMPL:   nxt_st.cfg.smpl   = ssrp_put_byte(st_ff.cfg.smpl, fw_addr[0], fw_data);
                    IDX_GCMD:
                    begin
                        if (!fw_addr[0])
                        begin
                            nxt_st.autonull = fw_data[CMD_AUTONULL_BIT];
                            nxt_st.save     = fw_data[CMD_SAVE_BIT];
                        end
                    end
                    default: ;
                endcase
            end
            else
            begin
                // Read data waits for the next frame, which may carry another read.
                case (fw_addr[6:1])
                    IDX_RATE:   nxt_st.rd_data = st_ff.rate_out;
                    IDX_OFFSET: nxt_st.rd_data = st_ff.cfg.offset;
                    IDX_GPIO:   nxt_st.rd_data = {14'h0000, st_ff.dio_sy1};
                    IDX_MISC:   nxt_st.rd_data = st_ff.cfg.misc;
                    IDX_SMPL:   nxt_st.rd_data = st_ff.cfg.smpl;
                    default:    nxt_st.rd_data = 16'h0000;
                endcase
                if (fw_addr[6:1] == IDX_RATE)
                begin
                    nxt_st.rate_out[OUT_ND_BIT] = 1'b0;
                end
            end
        end

        // Bias null: the offset cancels the present converter reading.
        if (st_ff.autonull)
        begin
            nxt_st.cfg.offset = 16'h0000 - {{2{rate_sample_in[13]}}, rate_sample_in};
        end

        // Sampler; a new sample sets the new-data flag even while a read clears it.
        if (st_ff.phase == SSRP_LOAD)
        begin
            nxt_st.cfg      = flash_cfg;
            nxt_st.phase    = SSRP_RUN;
            nxt_st.tick_cnt = 20'h00000;
        end
        else if (st_ff.tick_cnt == 20'h00000)
        begin
            sum   = {rate_sample_in[13], rate_sample_in} + {st_ff.prev_sample[13], st_ff.prev_sample};
            filt  = sum[14:1];
            corr  = filt + st_ff.cfg.offset[RATE_BITS-1:0];
            alarm = ($signed(corr) > $signed(RATE_ALARM_LIM)) ||
                    ($signed(corr) < -$signed(RATE_ALARM_LIM));
            nxt_st.rate_out    = {1'b1, alarm, corr};
            nxt_st.prev_sample = rate_sample_in;
            nxt_st.drdy_cnt    = DRDY_PULSE_CYC;
            nxt_st.tick_cnt    = 20'((32'(st_ff.cfg.smpl[7:0]) + 32'd1) * SAMPLE_BASE - 32'd1);
        end
        else
        begin
            nxt_st.tick_cnt = st_ff.tick_cnt - 20'h00001;
            if (st_ff.drdy_cnt != 4'h0)
            begin
                nxt_st.drdy_cnt = st_ff.drdy_cnt - 4'h1;
            end
        end

        // Data ready line: enable, polarity and line choice from misc control.
        for (int i = 0; i < 2; i++)
        begin
            if (nxt_st.cfg.misc[MISC_DR_EN_BIT] && (nxt_st.cfg.misc[MISC_DR_LINE_BIT] == i[0]))
            begin
                nxt_st.dio_oe_n[i] = 1'b0;
                nxt_st.dio[i] = (nxt_st.drdy_cnt != 4'h0) ? nxt_st.cfg.misc[MISC_DR_POL_BIT]
                                                          : ~nxt_st.cfg.misc[MISC_DR_POL_BIT];
            end
            else
            begin
                nxt_st.dio_oe_n[i] = 1'b1;
                nxt_st.dio[i]      = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign dout_out      = st_ff.dout;
    assign dout_oe_n_out = st_ff.dout_oe_n;
    assign dio_out       = st_ff.dio;
    assign dio_oe_n_out  = st_ff.dio_oe_n;
    assign autonull_out  = st_ff.autonull;

    // Checks on the port behaviour.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    a_msb_on_select: assert property (
        cs_fall |=> !dout_oe_n_out && (dout_out == $past(st_ff.rd_data[15])))
        else $error("MSB not driven after select.");

    a_release_deselect: assert property (
        !sel |=> dout_oe_n_out)
        else $error("Output driven while deselected.");

    a_capture_rise: assert property (
        sel && sclk_rise && !cs_fall |=>
        (st_ff.rx_sh[0] == $past(st_ff.din_sy[1])) && (st_ff.bit_cnt == $past(st_ff.bit_cnt) + 4'h1))
        else $error("Input bit not captured on rising edge.");

    a_shift_fall: assert property (
        sel && sclk_fall && (st_ff.bit_cnt != 4'h0) && !cs_fall |=> dout_out == $past(st_ff.tx_sh[14]))
        else $error("Output bit not advanced on falling edge.");

    a_first_fall_hold: assert property (
        sel && sclk_fall && (st_ff.bit_cnt == 4'h0) && !cs_fall |=> $stable(dout_out))
        else $error("MSB lost on first falling edge.");

    a_autonull_start: assert property (
        frame_done && running && (frame_word == 16'hbe01) |=> autonull_out ##1 !autonull_out)
        else $error("Bias null not started after the last bit.");

    a_flash_save: assert property (
        frame_done && running && (frame_word == 16'hbe08) |=> ##1 flash_cfg == $past(st_ff.cfg))
        else $error("Flash save did not store working settings.");

    a_flash_quiet: assert property (
        !st_ff.save |=> $stable(flash_cfg))
        else $error("Flash changed without a save command.");

    a_read_either_byte: assert property (
        frame_done && running && !fw_wr && (fw_addr[6:1] == IDX_RATE) |=>
        st_ff.rd_data == $past(st_ff.rate_out))
        else $error("Rate register not returned for its address.");

    // The load state also stands through the last reset edge; only the released one counts.
    a_reset_load: assert property (
        (st_ff.phase == SSRP_LOAD) && !srst_in |=>
        (st_ff.phase == SSRP_RUN) && (st_ff.cfg == $past(flash_cfg)))
        else $error("Working settings not loaded from flash.");

    a_ignore_unmapped: assert property (
        frame_done && running && fw_wr && !ssrp_writable(fw_addr) && !st_ff.autonull |=>
        st_ff.cfg == $past(st_ff.cfg))
        else $error("Unmapped write changed control state.");

    a_drdy_line: assert property (
        st_ff.cfg.misc[MISC_DR_EN_BIT] && (st_ff.drdy_cnt != 4'h0) |->
        !dio_oe_n_out[st_ff.cfg.misc[MISC_DR_LINE_BIT]] &&
        (dio_out[st_ff.cfg.misc[MISC_DR_LINE_BIT]] == st_ff.cfg.misc[MISC_DR_POL_BIT]))
        else $error("Data ready line not asserted.");

    a_sample_load: assert property (
        running && (st_ff.tick_cnt == 20'h00000) |=>
        st_ff.rate_out[OUT_ND_BIT] && (st_ff.drdy_cnt == DRDY_PULSE_CYC))
        else $error("Sample not loaded on tick.");

    c_write_frame: cover property (frame_done && running && fw_wr && ssrp_writable(fw_addr));
    c_read_frame:  cover property (frame_done && running && !fw_wr);
    c_pipelined:   cover property (frame_done && !fw_wr ##[1:400] cs_fall ##[1:400] frame_done && !fw_wr);
    c_autonull:    cover property (autonull_out);

endmodule : ssrp_port

/* File: ssrp_master.sv */
// Serial master model that drives mode 3 frames into the sensor port.
`timescale 1ns/100ps
module ssrp_master
    import ssrp_pkg::*;
(
    // Clock.
    input  wire logic           core_clk_in,
    // Link pins.
    output ssrp_pkg::ssrp_spi_t spi_out,
    input  wire logic           dout_in,
    input  wire logic           dout_oe_n_in
);
    logic busy = 1'b0;
    logic last = 1'b0;
    logic miso;

    // Clock idles high and the slave stays deselected until a frame starts.
    initial spi_out = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};

    // A released output reads as the inverse of its last value, so a stale bit never matches.
    assign miso = dout_oe_n_in ? ~last : dout_in;

    // Track the driven level and keep the idle input line moving between frames.
    always @(posedge core_clk_in)
    begin
        if (!dout_oe_n_in)
            last <= dout_in;
        if (!busy)
            spi_out.din <= ~spi_out.din;
    end

    // One 16-bit frame, MSB first, 800 ns clock; the reply shifts in at the same time.
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        busy = 1'b1;
        @(posedge core_clk_in);
        spi_out.cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (4) @(posedge core_clk_in);
            spi_out.sclk <= 1'b0;
            spi_out.din  <= tx[i];
            repeat (4) @(posedge core_clk_in);
            spi_out.sclk <= 1'b1;
            #1 rx[i] = miso;
        end
        repeat (4) @(posedge core_clk_in);
        spi_out.cs_n <= 1'b1;
        // The stall gap of the fast setting, 9 us at this clock.
        repeat (90) @(posedge core_clk_in);
        busy = 1'b0;
    endtask : frame
endmodule : ssrp_master

/* File: spi_sensor_register_port_test.sv */
// Self-checking bench for the sensor serial register port.
`timescale 1ns/100ps
module spi_sensor_register_port_test;
    import ssrp_pkg::*;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    ssrp_pkg::ssrp_spi_t spi;
    logic                dout;
    logic                oe_n;
    logic [1:0]          dio_ext = 2'b00;
    logic [1:0]          dio_drv;
    logic [1:0]          dio_oe_n;
    logic [1:0]          dio_w;
    logic [13:0]         smp = 14'h0000;
    logic                null_o;
    logic [15:0]         rx;
    int                  errors = 0;
    int                  checked = 0;
    int                  cyc = 0;
    int                  pulses = 0;
    int                  null_cyc = 0;

    // The digital lines resolve between the port and the outside world.
    assign dio_w = (dio_oe_n & dio_ext) | (~dio_oe_n & dio_drv);

    ssrp_port #(.SAMPLE_BASE(4)) i_dut (.core_clk_in(clk), .srst_in(srst), .spi_in(spi),
        .dout_out(dout), .dout_oe_n_out(oe_n), .dio_in(dio_w), .dio_out(dio_drv),
        .dio_oe_n_out(dio_oe_n), .rate_sample_in(smp), .autonull_out(null_o));
    ssrp_master i_master (.core_clk_in(clk), .spi_out(spi), .dout_in(dout),
        .dout_oe_n_in(oe_n));

    // A 100 ns clock.
    initial
    begin
        forever #50 clk = ~clk;
    end

    // Cycle count, hang limit and bias null pulse monitor.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (null_o)
        begin
            pulses   <= pulses + 1;
            null_cyc <= cyc;
        end
        if (cyc > 40000)
        begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : do_reset

    // One frame; the output must be released once the slave is deselected.
    task automatic xfer(input logic [15:0] tx);
        i_master.frame(tx, rx);
        check("dout release", {15'h0, oe_n}, 16'h0001);
    endtask : xfer

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xfer({1'b1, a, d});
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string what);
        xfer({1'b0, a, 8'h00});
        xfer(16'h0000);
        check(what, rx, exp);
    endtask : rd

    // New data flag set, alarm on magnitude above the limit, offset added.
    function automatic logic [15:0] exp_rate(input logic [13:0] s, input logic [13:0] off);
        logic [13:0] v;
        v = s + off;
        exp_rate = {1'b1, ((v[13] ? 14'h0 - v : v) > RATE_ALARM_LIM), v};
    endfunction : exp_rate

    // Data ready pulse width and spacing for one misc setting.
    task automatic drdy(input logic [2:0] cfg);
        int n;
        logic act;
        act = cfg[1];
        wr(ADDR_MISC, {5'h00, cfg});
        check("dio enable", {14'h0, dio_oe_n},
              {14'h0, cfg[2] ? ~(2'b01 << cfg[0]) : 2'b11});
        if (cfg[2])
        begin
            n = 0;
            while (dio_drv[cfg[0]] === act && n < 99) begin @(negedge clk); n++; end
            while (dio_drv[cfg[0]] !== act && n < 199) begin @(negedge clk); n++; end
            n = 0;
            while (dio_drv[cfg[0]] === act && n < 99) begin @(negedge clk); n++; end
            check("drdy width", 16'(n), 16'(DRDY_PULSE_CYC));
            while (dio_drv[cfg[0]] !== act && n < 99) begin @(negedge clk); n++; end
            check("tick spacing", 16'(n), 16'd16);
        end
    endtask : drdy

    initial
    begin
        logic [13:0] s;
        logic [15:0] off;
        logic [13:0] corner [5] = '{14'h1110, 14'h1111, 14'h2ef0, 14'h2eef, 14'h0000};
        void'($urandom(51));
        do_reset();
        // Defaults through upper byte addresses, back to back, then an unmapped place.
        xfer(16'h1500);
        xfer(16'h3500);
        check("offset rst", rx, OFFSET_RST);
        xfer(16'h3700);
        check("misc rst", rx, MISC_RST);
        xfer(16'h0600);
        check("smpl rst", rx, SMPL_RST);
        xfer(16'h0000);
        check("unmapped", rx, 16'h0000);
        $display("test reset done");
        // Rate output with corner and random samples and digital line readback.
        for (int i = 0; i < 8; i++)
        begin
            s = (i < 5) ? corner[i] : 14'($urandom);
            @(posedge clk);
            smp     <= s;
            dio_ext <= 2'($urandom);
            repeat (40) @(posedge clk);
            rd(ADDR_RATE, exp_rate(s, 14'h0000), "rate");
            xfer({1'b0, ADDR_GPIO, 8'h00});
            xfer(16'h0000);
            check("dio readback", {14'h0, rx[1:0]}, {14'h0, dio_ext});
        end
        $display("test rate done");
        // Byte writes, offset applied, ignored writes.
        off = 16'($urandom);
        wr(ADDR_OFFSET | 7'h01, off[15:8]);
        wr(ADDR_OFFSET, off[7:0]);
        wr(ADDR_RATE, 8'h55);
        wr(7'h06, 8'h55);
        wr(7'h3f, 8'h55);
        rd(ADDR_OFFSET, off, "offset");
        rd(ADDR_RATE | 7'h01, exp_rate(s, off[13:0]), "rate offset");
        $display("test write done");
        // Bias null starts right after the last rising edge, once.
        pulses = 0;
        xfer(16'hbe01);
        check("null count", 16'(pulses), 16'd1);
        check("null delay", 16'((cyc - null_cyc) inside {[86:92]}), 16'd1);
        xfer({1'b0, ADDR_OFFSET, 8'h00});
        xfer({1'b0, ADDR_RATE, 8'h00});
        check("null offset", {2'b00, rx[13:0]}, {2'b00, 14'h0 - s});
        xfer(16'h0000);
        check("null rate", rx, exp_rate(s, 14'h0 - s));
        $display("test autonull done");
        // Unsaved settings vanish on reset, saved ones come back.
        do_reset();
        rd(ADDR_OFFSET, OFFSET_RST, "unsaved");
        off = 16'($urandom);
        wr(ADDR_OFFSET | 7'h01, off[15:8]);
        wr(ADDR_OFFSET, off[7:0]);
        wr(ADDR_GCMD, 8'h08);
        wr(ADDR_OFFSET, ~off[7:0]);
        do_reset();
        rd(ADDR_OFFSET, off, "restored");
        $display("test flash done");
        // Data ready on each line and polarity, with a longer sample period.
        wr(ADDR_SMPL, 8'h03);
        drdy(3'b110);
        drdy(3'b111);
        drdy(3'b100);
        drdy(3'b101);
        drdy(3'b000);
        $display("test ready done");
        complete_run();
    end
endmodule : spi_sensor_register_port_test
